// File: common/tcp_defines.vh
// register map, field positions, reset values and timing counts of the timer block
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH

// register addresses on the cpu file bus
`define TCP_ADDR_TIMER        8'h01
`define TCP_ADDR_IRQ_CTRL     8'h0b
`define TCP_ADDR_IRQ_CTRL_HI  8'h8b
`define TCP_ADDR_OPTION       8'h81
`define TCP_ADDR_PORTA_DIR    8'h85

// option_config fields
`define TCP_OPT_CS            5
`define TCP_OPT_SE            4
`define TCP_OPT_PA            3
`define TCP_OPT_PR_HI         2
`define TCP_OPT_PR_LO         0

// irq_control_reg fields
`define TCP_IRQ_GIE           7
`define TCP_IRQ_OVF_EN        5
`define TCP_IRQ_OVF_FLAG      2

// port a direction field for the shared pin
`define TCP_DIR_PIN           4

// reset values
`define TCP_RST_OPTION        8'hff
`define TCP_RST_IRQ_CTRL      8'h00
`define TCP_RST_PORTA_DIR     5'h1f
`define TCP_RST_TIMER         8'h00

// timing: write inhibit cycles, phases per instruction cycle
`define TCP_INHIBIT_CYCLES    2'd2
`define TCP_PHASES            4

`endif

// File: design/tcp_prescaler.v
// shared 8-bit ripple-style prescaler with ratio tap selection
`timescale 1ns/1ps
`default_nettype none
module tcp_prescaler
#(
   parameter WIDTH = 8
)
(
   input  wire       clk,
   input  wire       rstn,
   input  wire       tick,
   input  wire       clear,
   input  wire [2:0] ratio,
   output reg        tap
);
   reg  [WIDTH-1:0] count;

   // divider count, cleared on request; not visible to software
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         count <= {WIDTH{1'b0}};
      else if (clear)
         count <= {WIDTH{1'b0}};
      else if (tick)
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
   end

   // symmetrical output: bit ratio of the count toggles at 1:2^(ratio+1)
   always @*
   begin
      tap = count[ratio];
   end
endmodule
`default_nettype wire

// File: design/tcp_sync2.v
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tcp_sync2
(
   input  wire clk,
   input  wire rstn,
   input  wire din,
   output wire dout
);
   reg stage_a;
   reg stage_b;

   // first stage read only by the second
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage_a <= 1'b0;
         stage_b <= 1'b0;
      end
      else
      begin
         stage_a <= din;
         stage_b <= stage_a;
      end
   end

   assign dout = stage_b;
endmodule
`default_nettype wire

// File: design/tcp_timer.v
// timer/counter with shared prescaler, overflow flag and cpu register access
//
// Contract
// - clock source clear: count once per instruction cycle without prescaler.
// - after a software write to the count, skip two instruction cycles.
// - clock source set: count pin edges; edge select clear rising, set falling.
// - assign bit clear gives prescaler to timer, set to watchdog.
// - timer prescale ratio selects 1:2 through 1:256 in powers of two.
// - prescaler is 8 bits and never readable or writable by software.
// - count wrap from ff to 00 sets the overflow flag.
// - cleared enable blocks the interrupt; flag still records overflow.
// - timer stops in sleep, so overflow cannot wake the processor.
// - prescaler output or raw pin is sampled on phases two and four.
// - external input divided by a ripple counter giving symmetrical output.
// - increment lands three to seven oscillator periods after a pin edge; the code takes eight to twelve at one phase per clock.
// - any timer write clears the prescaler while the timer owns it.
// - watchdog clear instruction clears the prescaler while the watchdog owns it.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.vh"
module tcp_timer
(
   input  wire       clk,
   input  wire       rstn,
   input  wire       phase_strobe,
   input  wire       sleep_mode,
   input  wire       wdt_tick,
   input  wire       watchdog_clear_instr,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       ext_count_input,
   output reg        overflow_irq,
   output reg        wdt_timeout,
   output reg        timer_inc,
   output reg        pin_dir
);
   // ------------------------------------------------------------
   // internal phase generation
   // ------------------------------------------------------------
   // phase_strobe marks each oscillator period; four make one instruction cycle
   reg  [1:0] phase;
   wire       phase_two;
   wire       phase_four;
   wire       cycle_end;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         phase <= 2'd0;
      else if (phase_strobe)
         phase <= phase + 2'd1;
   end

   assign phase_two  = phase_strobe && (phase == 2'd1);
   assign phase_four = phase_strobe && (phase == 2'd3);
   assign cycle_end  = phase_four;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg  [7:0] timer_count;
   reg  [7:0] option_config;
   reg  [7:0] irq_control_reg;
   reg  [4:0] port_a_direction;
   reg  [1:0] inhibit;

   wire clock_source_select = option_config[`TCP_OPT_CS];
   wire source_edge_select  = option_config[`TCP_OPT_SE];
   wire prescaler_assign    = option_config[`TCP_OPT_PA];
   wire [2:0] prescale_ratio = option_config[`TCP_OPT_PR_HI:`TCP_OPT_PR_LO];
   wire overflow_irq_enable = irq_control_reg[`TCP_IRQ_OVF_EN];
   wire global_irq_enable   = irq_control_reg[`TCP_IRQ_GIE];

   wire wr_timer = reg_wr && (reg_addr == `TCP_ADDR_TIMER);
   wire wr_irq   = reg_wr && ((reg_addr == `TCP_ADDR_IRQ_CTRL) ||
                              (reg_addr == `TCP_ADDR_IRQ_CTRL_HI));
   wire wr_opt   = reg_wr && (reg_addr == `TCP_ADDR_OPTION);
   wire wr_dir   = reg_wr && (reg_addr == `TCP_ADDR_PORTA_DIR);

   // ------------------------------------------------------------
   // external input path
   // ------------------------------------------------------------
   wire pin_sync;
   reg  pin_prev;
   wire pin_edge;

   tcp_sync2 u_pin_sync
   (
      .clk  (clk),
      .rstn (rstn),
      .din  (ext_count_input),
      .dout (pin_sync)
   );

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pin_prev <= 1'b0;
      else
         pin_prev <= pin_sync;
   end

   assign pin_edge = source_edge_select ? (pin_prev && !pin_sync)
                                        : (!pin_prev && pin_sync);

   // ------------------------------------------------------------
   // shared prescaler
   // ------------------------------------------------------------
   wire to_timer = !prescaler_assign;
   wire src_tick = clock_source_select ? pin_edge : cycle_end;
   wire pre_tick;
   wire pre_clear;
   wire pre_tap;

   // prescaler fed by exactly one owner
   assign pre_tick  = to_timer ? src_tick : wdt_tick;
   assign pre_clear = to_timer ? wr_timer : watchdog_clear_instr;

   // count kept inside, no register path
   tcp_prescaler #(.WIDTH(8)) u_prescaler
   (
      .clk   (clk),
      .rstn  (rstn),
      .tick  (pre_tick && !sleep_mode),
      .clear (pre_clear),
      .ratio (prescale_ratio),
      .tap   (pre_tap)
   );

   // ------------------------------------------------------------
   // phase sampling of the counting source
   // ------------------------------------------------------------
   // source level: prescaler tap, or raw pin inverted when falling edge is selected
   reg  src_level;
   reg  samp_q2;
   reg  samp_q4;
   reg  samp_q4_prev;
   wire ext_inc;

   always @*
   begin
      if (to_timer)
         src_level = pre_tap;
      else
         src_level = source_edge_select ? !pin_sync : pin_sync;
   end

   // sample on phase two, then phase four
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // idle low pin seen through reset falling select reads high: no false edge
         samp_q2      <= 1'b1;
         samp_q4      <= 1'b1;
         samp_q4_prev <= 1'b1;
      end
      else
      begin
         if (phase_two)
            samp_q2 <= src_level;
         if (phase_four)
         begin
            samp_q4      <= samp_q2;
            samp_q4_prev <= samp_q4;
         end
      end
   end

   // rising sampled level at a cycle end gives one increment
   assign ext_inc = cycle_end && samp_q4 && !samp_q4_prev;

   // ------------------------------------------------------------
   // increment decision
   // ------------------------------------------------------------
   reg next_inc;

   always @*
   begin
      next_inc = 1'b0;
      if (clock_source_select || to_timer)
         // prescaled or external count through sampler
         next_inc = ext_inc;
      else
         next_inc = cycle_end;
      if (sleep_mode)
         next_inc = 1'b0;
   end

   // ------------------------------------------------------------
   // timer count, inhibit and overflow
   // ------------------------------------------------------------
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         timer_count <= `TCP_RST_TIMER;
         inhibit     <= 2'd0;
      end
      else if (wr_timer)
      begin
         timer_count <= reg_wdata;
         // hold off the next two cycles
         inhibit     <= `TCP_INHIBIT_CYCLES;
      end
      else
      begin
         // hold-off counts instruction cycles, not increments
         if (cycle_end && (inhibit != 2'd0))
            inhibit <= inhibit - 2'd1;
         if (next_inc && (inhibit == 2'd0))
            timer_count <= timer_count + 8'h01;
      end
   end

   wire wrap = next_inc && !wr_timer && (inhibit == 2'd0) && (timer_count == 8'hff);

   // irq control register; overflow set beats software clear
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         irq_control_reg <= `TCP_RST_IRQ_CTRL;
      else
      begin
         if (wr_irq)
            irq_control_reg <= reg_wdata;
         if (wrap)
            irq_control_reg[`TCP_IRQ_OVF_FLAG] <= 1'b1;
      end
   end

   // option and direction registers
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         option_config    <= `TCP_RST_OPTION;
         port_a_direction <= `TCP_RST_PORTA_DIR;
      end
      else
      begin
         if (wr_opt)
            option_config <= reg_wdata;
         if (wr_dir)
            port_a_direction <= reg_wdata[4:0];
      end
   end

   // ------------------------------------------------------------
   // read data and registered outputs
   // ------------------------------------------------------------
   reg [7:0] next_rdata;

   always @*
   begin
      case (reg_addr)
         `TCP_ADDR_TIMER:       next_rdata = timer_count;
         `TCP_ADDR_IRQ_CTRL:    next_rdata = irq_control_reg;
         `TCP_ADDR_IRQ_CTRL_HI: next_rdata = irq_control_reg;
         `TCP_ADDR_OPTION:      next_rdata = option_config;
         `TCP_ADDR_PORTA_DIR:   next_rdata = {3'h0, port_a_direction};
         default:               next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata    <= 8'h00;
         overflow_irq <= 1'b0;
         wdt_timeout  <= 1'b0;
         timer_inc    <= 1'b0;
         pin_dir      <= 1'b1;
      end
      else
      begin
         if (reg_rd)
            reg_rdata <= next_rdata;
         // enable gates the request, flag untouched
         overflow_irq <= irq_control_reg[`TCP_IRQ_OVF_FLAG] && overflow_irq_enable
                         && global_irq_enable;
         // postscaled watchdog tick, or raw tick when timer owns prescaler
         wdt_timeout  <= prescaler_assign ? (pre_tap && wdt_tick) : wdt_tick;
         timer_inc    <= next_inc && (inhibit == 2'd0) && !wr_timer;
         pin_dir      <= port_a_direction[`TCP_DIR_PIN];
      end
   end
endmodule
`default_nettype wire

// File: dv/tcp_pin_src.sv
// model of the external clock source on the count pin
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_src
(
   output var logic pin
);
   initial pin = 1'b0;
   // slow symmetric pulses, one rise and one fall each, ends low
   task burst(input integer n);
   begin
      #3;
      repeat (n)
      begin
         pin = 1'b1;
         #100;
         pin = 1'b0;
         #100;
      end
   end
   endtask
   // back to the idle low level
   task idle;
   begin
      pin = 1'b0;
   end
   endtask
endmodule
`default_nettype wire

// File: dv/tcp_timer_asserts.sv
// assertion checker bound to the timer block ports
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_asserts
(
   input wire       clk,
   input wire       rstn,
   input wire       sleep_mode,
   input wire       wdt_tick,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       overflow_irq,
   input wire       wdt_timeout,
   input wire       timer_inc,
   input wire       pin_dir
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // both interrupt enables as last written
   reg  en;
   wire unmapped = !(reg_addr inside {8'h01, 8'h0b, 8'h8b, 8'h81, 8'h85});
   always @(posedge clk or negedge rstn)
      if (!rstn)
         en <= 1'b0;
      else if (reg_wr && (reg_addr == 8'h0b || reg_addr == 8'h8b))
         en <= reg_wdata[7] & reg_wdata[5];
   a_sleep_no_inc: assert property (sleep_mode [*3] |-> !timer_inc)
      else $error("timer moved during sleep");
   a_write_inhibit: assert property (
      reg_wr && reg_addr == 8'h01 |=> !timer_inc [*5])
      else $error("increment too soon after count write");
   a_irq_masked: assert property (!en [*2] |-> !overflow_irq)
      else $error("interrupt while masked");
   a_irq_cause: assert property ($rose(overflow_irq) |-> $past(en))
      else $error("interrupt rose without enables");
   a_inc_spacing: assert property (timer_inc |=> !timer_inc [*3])
      else $error("two increments in one instruction cycle");
   a_wdt_cause: assert property (wdt_timeout |-> $past(wdt_tick))
      else $error("watchdog pulse without tick");
   a_unmapped_zero: assert property (reg_rd && unmapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_dir_follow: assert property (
      reg_wr && reg_addr == 8'h85 |-> ##2 pin_dir == $past(reg_wdata[4], 2))
      else $error("pin direction not following register");
   c_inc: cover property (timer_inc);
   c_irq: cover property ($rose(overflow_irq));
   c_wdt: cover property (wdt_timeout);
endmodule
bind tcp_timer tcp_timer_asserts u_chk
(
   .clk(clk), .rstn(rstn), .sleep_mode(sleep_mode), .wdt_tick(wdt_tick),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .overflow_irq(overflow_irq), .wdt_timeout(wdt_timeout),
   .timer_inc(timer_inc), .pin_dir(pin_dir)
);
`default_nettype wire

// File: dv/tcp_timer_bench.sv
// self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_bench;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       phase_strobe = 1'b1; // one phase per clock
   logic       sleep_mode = 1'b0;
   logic       wdt_tick = 1'b0;
   logic       wd_clr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   wire  [7:0] reg_rdata;
   wire        ext_pin, overflow_irq, wdt_timeout, timer_inc, pin_dir;
   integer     num_errors = 0;
   integer     cmp_count = 0;
   integer     inc_cnt = 0;
   integer     wdt_cnt = 0;
   integer     cyc = 0;
   integer     n0, r, wt;
   always #12.5 clk = ~clk;
   tcp_pin_src ext (.pin(ext_pin));
   tcp_timer dut
   (
      .clk(clk), .rstn(rstn), .phase_strobe(phase_strobe), .sleep_mode(sleep_mode),
      .wdt_tick(wdt_tick), .watchdog_clear_instr(wd_clr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_count_input(ext_pin), .overflow_irq(overflow_irq),
      .wdt_timeout(wdt_timeout), .timer_inc(timer_inc), .pin_dir(pin_dir)
   );
   // event counters and hang guard
   always @(posedge clk)
   begin
      inc_cnt <= inc_cnt + timer_inc;
      wdt_cnt <= wdt_cnt + wdt_timeout;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         num_errors = num_errors + 1;
         results;
      end
   end
   // compare one value
   task chk(input [15:0] got, input [15:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // register bus cycles
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   end
   endtask
   task rd(input [7:0] a, input [7:0] e);
   begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   end
   endtask
   // wait for k increments, wt holds clocks waited
   task waitinc(input integer k);
   begin
      wt = 0;
      while (k > 0 && wt < 3000)
      begin
         @(negedge clk);
         wt = wt + 1;
         if (timer_inc === 1'b1)
            k = k - 1;
      end
   end
   endtask
   // watchdog tick (1) or clear instruction (0)
   task pulse(input w);
   begin
      @(negedge clk);
      if (w)
         wdt_tick = 1'b1;
      else
         wd_clr = 1'b1;
      @(negedge clk);
      wdt_tick = 1'b0;
      wd_clr = 1'b0;
      repeat (4) @(negedge clk);
   end
   endtask
   // pin burst of n rises, counted increments
   task pins(input integer n, input [15:0] e);
   begin
      repeat (20) @(negedge clk);
      n0 = inc_cnt;
      ext.burst(n);
      repeat (20) @(negedge clk);
      chk(inc_cnt - n0, e);
      ext.idle;
   end
   endtask
   // verdict
   task results;
   begin
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      rd(8'h01, 8'h00);
      rd(8'h0b, 8'h00);
      rd(8'h81, 8'hff);
      rd(8'h85, 8'h1f);
      chk(pin_dir, 16'h0001);
      rd(8'h02, 8'h00);
      wr(8'h85, 8'h0f);
      rd(8'h85, 8'h0f);
      chk(pin_dir, 16'h0000);
      $display("test registers done");
      wr(8'h81, 8'h08);
      wr(8'h01, 8'hfd);
      waitinc(3);
      rd(8'h01, 8'h00);
      rd(8'h0b, 8'h04);
      chk(overflow_irq, 16'h0000);
      wr(8'h0b, 8'ha0);
      wr(8'h01, 8'hff);
      waitinc(1);
      @(negedge clk); // request follows the flag by one edge
      chk(overflow_irq, 16'h0001);
      wr(8'h0b, 8'h00);
      $display("test overflow done");
      for (r = 0; r < 8; r = r + 1)
      begin
         wr(8'h81, r[7:0]);
         wr(8'h01, 8'h00);
         waitinc(1);
         waitinc(1);
         chk(wt, 16'd8 << r);
      end
      $display("test ratios done");
      wr(8'h81, 8'h28);
      pins(3, 16'd3);
      wr(8'h81, 8'h38);
      pins(3, 16'd3);
      wr(8'h81, 8'h20);
      wr(8'h01, 8'h00);
      pins(8, 16'd4);
      $display("test counter done");
      wr(8'h81, 8'h08);
      sleep_mode = 1'b1;
      repeat (4) @(negedge clk);
      n0 = inc_cnt;
      repeat (40) @(negedge clk);
      chk(inc_cnt - n0, 16'd0);
      sleep_mode = 1'b0;
      $display("test sleep done");
      pulse(1'b0);
      wr(8'h81, 8'h09);
      n0 = wdt_cnt;
      repeat (4) pulse(1'b1);
      chk(wdt_cnt - n0, 16'd2);
      n0 = wdt_cnt;
      repeat (3)
      begin
         pulse(1'b0);
         pulse(1'b1);
      end
      chk(wdt_cnt - n0, 16'd0);
      pulse(1'b0);
      wr(8'h81, 8'h01);
      n0 = wdt_cnt;
      repeat (3) pulse(1'b1);
      chk(wdt_cnt - n0, 16'd3);
      $display("test watchdog done");
      results;
   end
endmodule
`default_nettype wire
